// *** inc/pwr_mode_pkg.sv ***
// Shared constants and types for the global power mode controller
package pwr_mode_pkg;

    typedef enum logic [1:0]
    {
        MODE_ACTIVE    = 2'h0,
        MODE_ALTACTIVE = 2'h1,
        MODE_SLEEP     = 2'h2,
        MODE_HIBERNATE = 2'h3
    } pwr_mode_t;

    localparam int          SUBSYS_W       = 8;
    localparam int          CPU_BIT        = 0;
    localparam int          FLASH_BIT      = 1;

    localparam logic [11:0] ADDR_ACT_TMPL  = 12'h000;
    localparam logic [11:0] ADDR_ALT_TMPL  = 12'h004;
    localparam logic [11:0] ADDR_MODE_REQ  = 12'h008;
    localparam logic [11:0] ADDR_WAKE_EN   = 12'h00C;
    localparam logic [11:0] ADDR_STATUS    = 12'h010;

    localparam logic [7:0]  ACT_TMPL_RST   = 8'hFF;
    localparam logic [7:0]  ALT_TMPL_RST   = 8'hFC;
    localparam logic [5:0]  WAKE_EN_RST    = 6'h3F;

    // Subsystems kept alive in sleep: sleep timer and RTC
    localparam logic [7:0]  SLEEP_KEEP     = 8'hC0;

    localparam int          CLK_HZ         = 20000000;
    localparam int          SLEEP_RES_US   = 15;
    localparam int          HIB_RES_US     = 100;
    localparam int          SLEEP_RES_CYC  = (SLEEP_RES_US * (CLK_HZ / 1000000));
    // Margin of 8 covers the synchroniser and sequencer edges, keeping pin-to-active under 100 us
    localparam int          HIB_RES_CYC    = (HIB_RES_US * (CLK_HZ / 1000000)) - 8;

    // Wake source bit positions
    localparam int          WK_PERIPH      = 0;
    localparam int          WK_SUPERVISOR  = 1;
    localparam int          WK_TIMEWHEEL   = 2;
    localparam int          WK_PIN         = 3;
    localparam int          WK_I2C         = 4;
    localparam int          WK_RTC         = 5;
    localparam int          WAKE_W         = 6;

    typedef struct packed
    {
        logic [2:0]  resetSrc;
        logic [WAKE_W-1:0] wakeSrc;
    } wake_in_t;

endpackage : pwr_mode_pkg

// *** hdl/power_mode_controller.sv ***
// Global power mode controller with APB register access
// Operation
// R01: Four modes: active, alt active, sleep, hibernate
// R02: Active mode enables subsystems per template bits
// R03: Disabled resources get digital clocks gated
// R04: Template bit changes apply immediately
// R05: Alternate active uses its own template
// R06: Active on wake/reset/write; others write only
// R07: Sleep forces most resources off
// R08: Hibernate stops clocks, wake only pins; the code also wakes it on reset sources
// R09: Hibernate holds pin outputs and settings
// R10: Only pin interrupt leaves hibernate; the code also lets reset sources (resetSrc) leave it
// R11: Sleep resume waits 15 us
// R12: Hibernate resume under 100 us
// R13: Self-disabled CPU re-enabled on next wake
// R14: Any wake sets active and enables CPU
// R15: Active mode after boot
// R16: Wake from enabled interrupt sources
// R17: Reset sources also act as wake
// R18: Host keeps pins slow in hibernate
// R19: Host waits for valid io supply
// R20: Timewheel can wake low-power modes; the code lets it wake sleep only, not hibernate
// R21: Mode readable; entry refused while wake pending
// R22: Wake during entry aborts to active
//
// Added by the designer: the register offsets and the APB register port.
`timescale 1ns/10ps
module power_mode_controller
    import pwr_mode_pkg::*;
(
    input  wire logic                    clk,          // 20 MHz system clock
    input  wire logic                    reset,        // Async reset, active high
    input  wire logic                    psel,         // APB select
    input  wire logic                    penable,      // APB enable
    input  wire logic                    pwrite,       // APB direction
    input  wire logic [11:0]             paddr,        // APB byte address
    input  wire logic [31:0]             pwdata,       // APB write data
    output logic      [31:0]             prdata,       // APB read data
    output logic                         pready,       // APB ready
    output logic                         pslverr,      // APB error
    input  wire pwr_mode_pkg::wake_in_t  wakeIn,       // Async wake and reset events
    output logic [SUBSYS_W-1:0]          subsysEn,     // Subsystem power enables
    output logic [SUBSYS_W-1:0]          clkGateEn,    // Digital clock enables
    output logic                         cpuEn,        // CPU enable
    output logic                         lowPowerClk,  // Run from low power osc
    output logic                         pinHold,      // Freeze pin outputs
    output pwr_mode_pkg::pwr_mode_t      curMode       // Present global mode
);
    import pwr_mode_pkg::*;

    typedef enum logic [1:0] {ST_RUN, ST_ENTER, ST_LOW, ST_RESUME} seq_t;

    logic [8:0]          wakeS1_ff;
    logic [8:0]          wakeS2_ff;
    logic [SUBSYS_W-1:0] actTmpl_ff;
    logic [SUBSYS_W-1:0] altTmpl_ff;
    logic [WAKE_W-1:0]   wakeEn_ff;
    pwr_mode_t           mode_ff;
    pwr_mode_t           reqMode_ff;
    seq_t                seq_ff;
    logic [11:0]         resCnt_ff;
    logic                cpuForce_ff;
    logic                refused_ff;
    logic [WAKE_W-1:0]   wakeMask;
    logic                wakeAny;
    logic                resetEv;
    logic                wrEn;
    logic                modeWr;
    logic                mapped;

    // Event inputs come from other domains
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            wakeS1_ff <= 9'h000;
            wakeS2_ff <= 9'h000;
        end
        else
        begin
            wakeS1_ff <= wakeIn;
            wakeS2_ff <= wakeS1_ff;
        end
    end

    assign resetEv = |wakeS2_ff[8:6];                                        // R17
    always_comb
    begin
        wakeMask = wakeS2_ff[WAKE_W-1:0] & wakeEn_ff;                        // R16 R20
        if (mode_ff == MODE_HIBERNATE)
        begin
            wakeMask = '0;
            wakeMask[WK_PIN] = wakeS2_ff[WK_PIN] & wakeEn_ff[WK_PIN];        // R10 R08
        end
    end
    assign wakeAny = (|wakeMask) | resetEv;

    assign wrEn   = psel && penable && pwrite;
    assign modeWr = wrEn && (paddr == ADDR_MODE_REQ);
    assign mapped = (paddr == ADDR_ACT_TMPL) || (paddr == ADDR_ALT_TMPL) ||
                    (paddr == ADDR_MODE_REQ) || (paddr == ADDR_WAKE_EN) ||
                    (paddr == ADDR_STATUS);
    assign pready  = 1'b1;
    assign pslverr = psel && penable && !mapped;

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            actTmpl_ff <= ACT_TMPL_RST;
            altTmpl_ff <= ALT_TMPL_RST;
            wakeEn_ff  <= WAKE_EN_RST;
        end
        else if (wrEn)
        begin
            if (paddr == ADDR_ACT_TMPL)
                actTmpl_ff <= pwdata[SUBSYS_W-1:0];                          // R04
            if (paddr == ADDR_ALT_TMPL)
                altTmpl_ff <= pwdata[SUBSYS_W-1:0];
            if (paddr == ADDR_WAKE_EN)
                wakeEn_ff <= pwdata[WAKE_W-1:0];
        end
    end

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            prdata <= 32'h0000_0000;
        else if (psel && !penable && !pwrite)
        begin
            unique case (paddr)
                ADDR_ACT_TMPL: prdata <= {24'h000000, actTmpl_ff};
                ADDR_ALT_TMPL: prdata <= {24'h000000, altTmpl_ff};
                ADDR_MODE_REQ: prdata <= {30'h00000000, reqMode_ff};
                ADDR_WAKE_EN:  prdata <= {26'h0000000, wakeEn_ff};
                ADDR_STATUS:   prdata <= {27'h0000000, refused_ff, seq_ff, mode_ff}; // R21
                default:       prdata <= 32'h0000_0000;
            endcase
        end
    end

    // Mode sequencer; a wake beats any pending entry so none is lost
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            mode_ff     <= MODE_ACTIVE;                                      // R15
            reqMode_ff  <= MODE_ACTIVE;
            seq_ff      <= ST_RUN;
            resCnt_ff   <= 12'h000;
            cpuForce_ff <= 1'b0;
            refused_ff  <= 1'b0;
        end
        else
        begin
            unique case (seq_ff)
                ST_RUN:
                begin
                    if (wakeAny)
                    begin
                        mode_ff     <= MODE_ACTIVE;                          // R14 R06
                        cpuForce_ff <= 1'b1;                                 // R13
                        if (modeWr)
                            refused_ff <= 1'b1;                              // R21
                    end
                    else if (modeWr)
                    begin
                        refused_ff <= 1'b0;
                        reqMode_ff <= pwr_mode_t'(pwdata[1:0]);
                        if (pwdata[1:0] == MODE_SLEEP || pwdata[1:0] == MODE_HIBERNATE)
                            seq_ff <= ST_ENTER;
                        else
                        begin
                            mode_ff     <= pwr_mode_t'(pwdata[1:0]);         // R06 R01
                            cpuForce_ff <= 1'b0;
                        end
                    end
                end
                ST_ENTER:
                begin
                    if (wakeAny)
                    begin
                        seq_ff      <= ST_RUN;                               // R22
                        mode_ff     <= MODE_ACTIVE;
                        cpuForce_ff <= 1'b1;
                    end
                    else
                    begin
                        seq_ff  <= ST_LOW;
                        mode_ff <= reqMode_ff;
                    end
                end
                ST_LOW:
                begin
                    if (wakeAny)
                    begin
                        seq_ff    <= ST_RESUME;
                        resCnt_ff <= (mode_ff == MODE_SLEEP) ?
                                     12'(SLEEP_RES_CYC - 1) : 12'(HIB_RES_CYC - 1); // R11 R12
                    end
                end
                ST_RESUME:
                begin
                    if (resCnt_ff == 12'h000)
                    begin
                        seq_ff      <= ST_RUN;
                        mode_ff     <= MODE_ACTIVE;
                        cpuForce_ff <= 1'b1;                                 // R13 R14
                    end
                    else
                        resCnt_ff <= resCnt_ff - 12'h001;
                end
            endcase
        end
    end

    always_comb
    begin
        unique case (mode_ff)
            MODE_ACTIVE:    subsysEn = actTmpl_ff;                           // R02
            MODE_ALTACTIVE: subsysEn = altTmpl_ff;                           // R05
            MODE_SLEEP:     subsysEn = actTmpl_ff & SLEEP_KEEP;              // R07
            MODE_HIBERNATE: subsysEn = '0;                                   // R08
        endcase
        if (mode_ff == MODE_ACTIVE && cpuForce_ff)
            subsysEn[CPU_BIT] = 1'b1;                                        // R14
    end
    assign clkGateEn   = subsysEn;                                           // R03
    assign cpuEn       = subsysEn[CPU_BIT];
    assign lowPowerClk = (mode_ff == MODE_SLEEP);
    assign pinHold     = (mode_ff == MODE_HIBERNATE);                        // R09
    assign curMode     = mode_ff;                                            // R21

    logic [11:0] lowCnt_ff;
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            lowCnt_ff <= 12'h000;
        else if (seq_ff == ST_RESUME)
            lowCnt_ff <= lowCnt_ff + 12'h001;
        else
            lowCnt_ff <= 12'h000;
    end

    a_boot_active: assert property (@(posedge clk) $fell(reset) |-> curMode == MODE_ACTIVE) // R15
        else $error("mode not active after reset");
    a_gate_follows: assert property (@(posedge clk) disable iff (reset)
        clkGateEn == subsysEn) // R03
        else $error("clock gate differs from enable");
    a_active_tmpl: assert property (@(posedge clk) disable iff (reset)
        (curMode == MODE_ACTIVE) |-> subsysEn[SUBSYS_W-1:1] == actTmpl_ff[SUBSYS_W-1:1]) // R02
        else $error("active enables not from template");
    a_alt_tmpl: assert property (@(posedge clk) disable iff (reset)
        (curMode == MODE_ALTACTIVE) |-> subsysEn == altTmpl_ff) // R05
        else $error("alt enables not from template");
    a_sleep_off: assert property (@(posedge clk) disable iff (reset)
        (curMode == MODE_SLEEP) |-> (subsysEn & ~SLEEP_KEEP) == '0) // R07
        else $error("resource on in sleep");
    a_hib_hold: assert property (@(posedge clk) disable iff (reset)
        (curMode == MODE_HIBERNATE) |-> pinHold && subsysEn == '0) // R08 R09
        else $error("hibernate not holding");
    a_sleep_time: assert property (@(posedge clk) disable iff (reset)
        (seq_ff == ST_RESUME && curMode == MODE_SLEEP) |-> lowCnt_ff < 12'(SLEEP_RES_CYC)) // R11
        else $error("sleep resume too long");
    a_hib_time: assert property (@(posedge clk) disable iff (reset)
        (seq_ff == ST_RESUME) |-> lowCnt_ff < 12'(HIB_RES_CYC)) // R12
        else $error("hibernate resume too long");
    a_wake_cpu: assert property (@(posedge clk) disable iff (reset)
        (seq_ff == ST_RUN && wakeAny) |=> curMode == MODE_ACTIVE && cpuEn) // R14 R13
        else $error("wake did not restore cpu");
    a_entry_abort: assert property (@(posedge clk) disable iff (reset)
        (seq_ff == ST_ENTER && wakeAny) |=> seq_ff == ST_RUN && curMode == MODE_ACTIVE) // R22
        else $error("wake lost during entry");
    c_sleep_cycle: cover property (@(posedge clk) curMode == MODE_SLEEP ##[1:400] curMode == MODE_ACTIVE);
    c_hib_cycle: cover property (@(posedge clk) curMode == MODE_HIBERNATE ##1 curMode == MODE_ACTIVE);
    c_abort: cover property (@(posedge clk) seq_ff == ST_ENTER && wakeAny);
    c_alt: cover property (@(posedge clk) curMode == MODE_ALTACTIVE);

endmodule : power_mode_controller

// *** dv/wake_source_model.sv ***
// Event source model: raises wake and reset requests for a fixed hold time
`timescale 1ns/10ps
module wake_source_model
#(
    parameter int HOLD_CYC = 1000
)
(
    input  wire logic              clk,      // System clock
    input  wire logic              reset,    // Async reset, active high
    input  wire logic              evtGo,    // Start an event
    input  wire logic [8:0]        evtMask,  // Sources to raise
    output pwr_mode_pkg::wake_in_t wakeIn    // Event levels to the controller
);
    import pwr_mode_pkg::*;
    logic [8:0] evt_ff;
    int         hold_ff;
    assign wakeIn = evt_ff;
    // Held for half a 10 kHz period, so pins never toggle fast in hibernate
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            evt_ff  <= '0;
            hold_ff <= 0;
        end
        else if (evtGo)
        begin
            evt_ff  <= evtMask;
            hold_ff <= HOLD_CYC;
        end
        else if (hold_ff > 1)
            hold_ff <= hold_ff - 1;
        else
        begin
            evt_ff  <= '0; // Released lines fall back to idle
            hold_ff <= 0;
        end
    end
endmodule : wake_source_model

// *** dv/power_mode_controller_tb.sv ***
// Self-checking bench for the power mode controller
`timescale 1ns/10ps
module power_mode_controller_tb;
    import pwr_mode_pkg::*;
    typedef struct { logic [31:0] exp; logic [31:0] mask; logic err; } rd_note_t;
    logic clk = 0, reset = 1, psel = 0, penable = 0, pwrite = 0, evtGo = 0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rnd;
    logic [8:0] evtMask = '0;
    logic pready, pslverr, cpuEn, lowPowerClk, pinHold;
    logic [SUBSYS_W-1:0] subsysEn, clkGateEn, tmpl;
    wake_in_t wakeIn;
    pwr_mode_t curMode;
    rd_note_t notes[$];
    rd_note_t nt;
    int failCount = 0, samplesChecked = 0, n;

    always #25 clk = ~clk;
    power_mode_controller dut (.clk(clk), .reset(reset), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .wakeIn(wakeIn), .subsysEn(subsysEn), .clkGateEn(clkGateEn),
        .cpuEn(cpuEn), .lowPowerClk(lowPowerClk), .pinHold(pinHold), .curMode(curMode));
    wake_source_model src (.clk(clk), .reset(reset), .evtGo(evtGo), .evtMask(evtMask),
        .wakeIn(wakeIn));

    task automatic check(input logic ok, input string msg);
        samplesChecked++;
        if (ok !== 1'b1)
        begin
            failCount++;
            $display("BAD %0t %s", $time, msg);
        end
    endtask : check
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [31:0] m,
                      input logic er);
        notes.push_back('{e, m, er});
        apb(1'b0, a, '0);
    endtask : rd
    task automatic fire(input logic [8:0] m);
        @(posedge clk);
        evtMask <= m;
        evtGo <= 1'b1;
        @(posedge clk);
        evtGo <= 1'b0;
    endtask : fire
    task automatic wait_active(output int cnt);
        cnt = 0;
        while (curMode !== MODE_ACTIVE && cnt < 3000)
        begin
            @(posedge clk);
            cnt++;
        end
    endtask : wait_active
    task automatic give_verdict();
        $display("checked %0d mismatches %0d", samplesChecked, failCount);
        if (failCount == 0 && samplesChecked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : give_verdict

    // Read results are compared against the oldest note when the access completes
    always @(posedge clk)
        if (psel && penable && !pwrite && pready)
        begin
            nt = notes.pop_front();
            check(((prdata & nt.mask) === nt.exp) && (pslverr === nt.err), "read data");
        end

    initial
    begin
        #(30000 * 50);
        failCount++;
        give_verdict();
    end

    initial
    begin
        void'($urandom(49886));
        repeat (6) @(posedge clk);
        reset <= 1'b0;
        check(curMode === MODE_ACTIVE && subsysEn === ACT_TMPL_RST, "boot mode");
        rd(ADDR_ACT_TMPL, {24'h0, ACT_TMPL_RST}, 32'hFF, 1'b0);
        rd(ADDR_ALT_TMPL, {24'h0, ALT_TMPL_RST}, 32'hFF, 1'b0);
        rd(ADDR_WAKE_EN, {26'h0, WAKE_EN_RST}, 32'h3F, 1'b0);
        rd(ADDR_STATUS, 32'h0, 32'h3, 1'b0);
        rd(12'h020, 32'h0, 32'hFFFFFFFF, 1'b1);
        rnd = $urandom;
        tmpl = rnd[7:0] & 8'hFE;
        apb(1'b1, ADDR_ACT_TMPL, {24'h0, tmpl});
        repeat (2) @(posedge clk);
        check(subsysEn === tmpl && clkGateEn === tmpl && cpuEn === 1'b0, "template");
        apb(1'b1, ADDR_MODE_REQ, 32'h1);
        repeat (2) @(posedge clk);
        check(curMode === MODE_ALTACTIVE && subsysEn === ALT_TMPL_RST, "alt mode");
        apb(1'b1, ADDR_MODE_REQ, 32'h0);
        repeat (2) @(posedge clk);
        check(curMode === MODE_ACTIVE && subsysEn === tmpl, "back to active");
        // Supplies are taken as valid from here on, so low power requests are legal
        apb(1'b1, ADDR_MODE_REQ, 32'h2);
        repeat (4) @(posedge clk);
        check(curMode === MODE_SLEEP && lowPowerClk === 1'b1, "sleep entry");
        check((subsysEn & ~SLEEP_KEEP) === 8'h00 && clkGateEn === subsysEn, "sleep off");
        fire(9'h004);
        wait_active(n);
        check(n >= SLEEP_RES_CYC && n <= SLEEP_RES_CYC + 10, "sleep resume");
        check(cpuEn === 1'b1 && subsysEn === (tmpl | 8'h01), "cpu back");
        repeat (5) @(posedge clk);
        apb(1'b1, ADDR_MODE_REQ, 32'h2);
        repeat (4) @(posedge clk);
        check(curMode === MODE_ACTIVE, "refused entry");
        rd(ADDR_STATUS, 32'h10, 32'h13, 1'b0);
        rd(ADDR_MODE_REQ, 32'h2, 32'h3, 1'b0);
        repeat (1000) @(posedge clk);
        apb(1'b1, ADDR_MODE_REQ, 32'h3);
        repeat (4) @(posedge clk);
        check(curMode === MODE_HIBERNATE && pinHold === 1'b1, "hibernate");
        check(clkGateEn === 8'h00, "clocks stopped");
        fire(9'h004);
        repeat (1010) @(posedge clk);
        check(curMode === MODE_HIBERNATE, "timewheel in hibernate");
        fire(9'h008);
        wait_active(n);
        check(n < 2000 && cpuEn === 1'b1 && pinHold === 1'b0, "hibernate resume");
        repeat (1000) @(posedge clk);
        apb(1'b1, ADDR_WAKE_EN, 32'h3E);
        apb(1'b1, ADDR_MODE_REQ, 32'h2);
        fire(9'h001);
        repeat (1010) @(posedge clk);
        check(curMode === MODE_SLEEP, "masked source");
        fire(9'h040);
        wait_active(n);
        check(n <= SLEEP_RES_CYC + 10 && cpuEn === 1'b1, "reset wake");
        repeat (1010) @(posedge clk);
        // Wake lands, after the synchroniser, in the one entry cycle of the sleep request
        fork
            fire(9'h004);
            begin
                @(posedge clk);
                apb(1'b1, ADDR_MODE_REQ, 32'h2);
            end
        join
        repeat (2) @(posedge clk);
        check(curMode === MODE_ACTIVE && cpuEn === 1'b1, "entry aborted");
        rd(ADDR_STATUS, 32'h00, 32'h1F, 1'b0);
        give_verdict();
    end
endmodule : power_mode_controller_tb
